// ### hdl/dsu_pkg.sv
// Shared constants for the integrity strip and update copy engine.
// Assumes a 32-bit register bus and a byte-wide memory port.
package dsu_pkg;
    // Register map, byte addresses
    localparam logic [6:0] A_DESC = 7'h00;
    localparam logic [6:0] A_COMP = 7'h40;
    localparam logic [6:0] A_CTRL = 7'h60;
    // Descriptor word indices (byte offset / 4)
    localparam int W_OP = 1;
    localparam int W_SRC = 4;
    localparam int W_DST = 6;
    localparam int W_SIZE = 8;
    localparam int W_FLG = 10;
    localparam int W_SREF = 12;
    localparam int W_SAPP = 13;
    localparam int W_DREF = 14;
    localparam int W_DAPP = 15;
    // Operation codes, values arbitrary
    localparam logic [7:0] OP_STRIP = 8'h01;
    localparam logic [7:0] OP_UPDATE = 8'h02;
    // Completion status codes
    localparam logic [7:0] ST_NONE = 8'h00;
    localparam logic [7:0] ST_OK = 8'h01;
    localparam logic [7:0] ST_FAULT = 8'h03;
    localparam logic [7:0] ST_BADOP = 8'h10;
    localparam logic [7:0] ST_OVERLAP = 8'h11;
    localparam logic [7:0] ST_DIFERR = 8'h20;
    // Integrity status bits
    localparam int DS_GUARD = 0;
    localparam int DS_APP = 1;
    localparam int DS_REF = 2;
    localparam int DS_ALLF = 3;
    // Source flag bits
    localparam int SF_REF_FIX = 7;
    localparam int SF_REF_OFF = 6;
    localparam int SF_GRD_OFF = 5;
    localparam int SF_APP_INC = 4;
    localparam int SF_F_BOTH = 3;
    localparam int SF_F_APP = 2;
    localparam int SF_F_ALL = 1;
    localparam int SF_F_ERR = 0;
    // Destination flag bit
    localparam int DF_REF_PASS = 6;
    // Shared flag bits
    localparam int GF_INV_RES = 3;
    localparam int GF_INV_SEED = 2;
    localparam logic [15:0] CRC_POLY = 16'h8BB7;
    localparam logic [15:0] CRC_ONES = 16'hFFFF;
    localparam logic [12:0] DIF_BYTES = 13'h0008;
endpackage

// ### hdl/dsu_crc_byte.sv
// Guard checksum step: folds one byte into a 16-bit CRC.
// Purely combinational; the caller holds the running value.
`timescale 1ns/100ps
module dsu_crc_byte
    import dsu_pkg::*;
(
    input wire logic [15:0] crc_in,
    input wire logic [7:0] data,
    output logic [15:0] crc_out
);
    always_comb begin
        logic [15:0] c;
        c = crc_in ^ {data, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
        end
        crc_out = c;
    end
endmodule

// ### hdl/dsu_engine.sv
// Descriptor-driven copy engine that strips or regenerates integrity fields.
// Assumes an Avalon-MM register master and a byte-wide memory slave with
// waitrequest whose read data and fault flag stand when waitrequest is low.
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
module dsu_engine
    import dsu_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [6:0] av_address,
    input wire logic av_read,
    input wire logic av_write,
    input wire logic [31:0] av_writedata,
    input wire logic [3:0] av_byteenable,
    output logic [31:0] av_readdata,
    output logic av_waitrequest,
    output logic [63:0] mem_address,
    output logic mem_read,
    output logic mem_write,
    output logic [7:0] mem_writedata,
    input wire logic [7:0] mem_readdata,
    input wire logic mem_fault,
    input wire logic mem_waitrequest,
    output logic busy
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_RD = 4'b0010,
        S_WR = 4'b0100,
        S_CHK = 4'b1000
    } dsu_state_t;

    dsu_state_t state_reg;
    logic [31:0] desc_reg [16];
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [63:0] src_reg, dst_reg;
    logic [31:0] left_reg, done_reg;
    logic [12:0] pos_reg;
    logic [15:0] crc_reg;
    logic [63:0] rx_reg;
    logic [7:0] byte_reg;
    logic [31:0] sref_reg, dref_reg;
    logic [15:0] sapp_reg, dapp_reg;
    logic [7:0] st_reg, dst_st_reg;
    logic [31:0] cr_bytes_reg;
    logic [63:0] cr_fault_reg;

    // Descriptor fields, live from the descriptor words
    logic [7:0] opcode, sflg, dflg, gflg;
    logic [31:0] xfer;
    logic [15:0] smask, dmask;
    logic is_upd, is_strip;
    assign opcode = desc_reg[W_OP][31:24];
    assign xfer = desc_reg[W_SIZE];
    assign sflg = desc_reg[W_FLG][7:0];
    assign dflg = desc_reg[W_FLG][15:8];
    assign gflg = desc_reg[W_FLG][23:16];
    assign smask = desc_reg[W_SAPP][15:0];
    assign dmask = desc_reg[W_DAPP][15:0];
    assign is_upd = opcode == OP_UPDATE;
    assign is_strip = opcode == OP_STRIP;

    logic [12:0] blk_pay;
    always_comb begin
        case (gflg[1:0])
            2'b00: blk_pay = 13'd512;
            2'b01: blk_pay = 13'd520;
            2'b10: blk_pay = 13'd4096;
            default: blk_pay = 13'd4104;
        endcase
    end

    // Register bus: every access answers on the second edge
    logic acc, start, ovl;
    assign acc = av_read | av_write;
    assign av_waitrequest = acc & ~ack_reg;
    assign av_readdata = rdata_reg;
    assign busy = state_reg != S_IDLE;
    assign start = av_write & ack_reg & (av_address == A_CTRL) & av_writedata[0]
        & av_byteenable[0] & ~busy;
    // Whole transfer size used for both ranges; conservative for strip
    assign ovl = (xfer != 32'h0) && (src_reg < dst_reg + {32'h0, xfer})
        && (dst_reg < src_reg + {32'h0, xfer});

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= acc & ~ack_reg;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 16; i++) begin
                desc_reg[i] <= 32'h0;
            end
        end else if (av_write && ack_reg && !busy && av_address < A_COMP) begin
            for (int b = 0; b < 4; b++) begin
                if (av_byteenable[b]) begin
                    desc_reg[av_address[5:2]][8*b +: 8] <= av_writedata[8*b +: 8];
                end
            end
        end
    end

    logic [31:0] comp_word;
    always_comb begin
        case (av_address[4:2])
            3'd0: comp_word = {16'h0, dst_st_reg, st_reg};
            3'd1: comp_word = cr_bytes_reg;
            3'd2: comp_word = cr_fault_reg[31:0];
            3'd3: comp_word = cr_fault_reg[63:32];
            3'd4: comp_word = sref_reg;
            3'd5: comp_word = {sapp_reg, smask};
            3'd6: comp_word = is_upd ? dref_reg : 32'h0;
            default: comp_word = is_upd ? {dapp_reg, dmask} : 32'h0;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 32'h0;
        end else if (av_read && !ack_reg) begin
            if (av_address < A_COMP) begin
                rdata_reg <= desc_reg[av_address[5:2]];
            end else if (av_address < A_CTRL) begin
                rdata_reg <= comp_word;
            end else if (av_address == A_CTRL) begin
                rdata_reg <= {31'h0, busy};
            end else begin
                rdata_reg <= 32'h0;
            end
        end
    end

    // Datapath helpers
    logic rd_ack, wr_ack, in_dif, need_wr, step, blk_end, last;
    logic [2:0] k;
    logic [15:0] crc_next, guard;
    logic [63:0] gen;
    logic [7:0] gen_byte;
    assign rd_ack = state_reg == S_RD && !mem_waitrequest;
    assign wr_ack = state_reg == S_WR && !mem_waitrequest;
    assign in_dif = pos_reg >= blk_pay;
    assign need_wr = is_upd | ~in_dif;
    assign step = (rd_ack & ~mem_fault & ~need_wr) | (wr_ack & ~mem_fault);
    assign blk_end = pos_reg == blk_pay + DIF_BYTES - 13'd1;
    assign last = left_reg == 32'h1;
    assign k = 3'(pos_reg - blk_pay);
    assign guard = crc_reg ^ (gflg[GF_INV_RES] ? CRC_ONES : 16'h0);
    assign gen = {guard, dapp_reg, dref_reg};
    always_comb begin
        gen_byte = gen[8*(7 - k) +: 8];
        if (k >= 3'd4 && dflg[DF_REF_PASS]) begin
            gen_byte = byte_reg;
        end
    end

    dsu_crc_byte u_crc (
        .crc_in(crc_reg),
        .data(mem_readdata),
        .crc_out(crc_next)
    );

    // Block check over the received field
    logic [15:0] rx_grd, rx_app;
    logic [31:0] rx_ref;
    logic app_f, all_f, skip, g_err, a_err, r_err, f_err, blk_err;
    assign rx_grd = rx_reg[63:48];
    assign rx_app = rx_reg[47:32];
    assign rx_ref = rx_reg[31:0];
    assign app_f = rx_app == 16'hFFFF;
    assign all_f = app_f && rx_ref == 32'hFFFFFFFF && rx_grd == 16'hFFFF;
    assign skip = (sflg[SF_F_APP] & app_f) | (sflg[SF_F_ALL] & all_f)
        | (sflg[SF_F_BOTH] & app_f & (rx_ref == 32'hFFFFFFFF));
    assign g_err = ~skip & ~sflg[SF_GRD_OFF] & (rx_grd != guard);
    assign a_err = ~skip & (((rx_app ^ sapp_reg) & ~smask) != 16'h0);
    assign r_err = ~skip & ~sflg[SF_REF_OFF] & (rx_ref != sref_reg);
    assign f_err = sflg[SF_F_ALL] & sflg[SF_F_ERR] & all_f;
    assign blk_err = g_err | a_err | r_err | f_err;
    logic [7:0] dif_code;
    always_comb begin
        dif_code = 8'h0;
        dif_code[DS_GUARD] = g_err;
        dif_code[DS_APP] = a_err;
        dif_code[DS_REF] = r_err;
        dif_code[DS_ALLF] = f_err;
    end

    // Sequencer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= S_IDLE;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (start && (is_upd || is_strip) && !ovl && xfer != 32'h0) begin
                        state_reg <= S_RD;
                    end
                end
                S_RD: begin
                    if (rd_ack) begin
                        if (mem_fault) begin
                            state_reg <= S_IDLE;
                        end else if (need_wr) begin
                            state_reg <= S_WR;
                        end else if (blk_end) begin
                            state_reg <= S_CHK;
                        end else if (last) begin
                            state_reg <= S_IDLE;
                        end
                    end
                end
                S_WR: begin
                    if (wr_ack) begin
                        if (mem_fault) begin
                            state_reg <= S_IDLE;
                        end else if (blk_end) begin
                            state_reg <= S_CHK;
                        end else if (last) begin
                            state_reg <= S_IDLE;
                        end else begin
                            state_reg <= S_RD;
                        end
                    end
                end
                S_CHK: begin
                    state_reg <= (blk_err || left_reg == 32'h0) ? S_IDLE : S_RD;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // Pointers, counters and running checksum; byte access keeps any alignment
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            src_reg <= 64'h0;
            dst_reg <= 64'h0;
            left_reg <= 32'h0;
            pos_reg <= 13'h0;
            crc_reg <= 16'h0;
            rx_reg <= 64'h0;
            byte_reg <= 8'h0;
            done_reg <= 32'h0;
        end else if (state_reg == S_IDLE) begin
            src_reg <= {desc_reg[W_SRC + 1], desc_reg[W_SRC]};
            dst_reg <= {desc_reg[W_DST + 1], desc_reg[W_DST]};
            left_reg <= xfer;
            pos_reg <= 13'h0;
            crc_reg <= gflg[GF_INV_SEED] ? CRC_ONES : 16'h0;
            done_reg <= 32'h0;
        end else begin
            if (rd_ack && !mem_fault) begin
                src_reg <= src_reg + 64'h1;
                byte_reg <= mem_readdata;
                if (in_dif) begin
                    rx_reg <= {rx_reg[55:0], mem_readdata};
                end else begin
                    crc_reg <= crc_next;
                end
            end
            if (wr_ack && !mem_fault) begin
                dst_reg <= dst_reg + 64'h1;
            end
            if (step) begin
                pos_reg <= pos_reg + 13'h1;
                left_reg <= left_reg - 32'h1;
            end
            if (state_reg == S_CHK && !blk_err) begin
                pos_reg <= 13'h0;
                crc_reg <= gflg[GF_INV_SEED] ? CRC_ONES : 16'h0;
                done_reg <= done_reg + 32'(blk_pay + DIF_BYTES);
            end
        end
    end

    // Running tags; after each good block each one steps, loads or holds as its flags select
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sref_reg <= 32'h0;
            sapp_reg <= 16'h0;
            dref_reg <= 32'h0;
            dapp_reg <= 16'h0;
        end else if (start) begin
            sref_reg <= desc_reg[W_SREF];
            sapp_reg <= desc_reg[W_SAPP][31:16];
            dref_reg <= desc_reg[W_DREF];
            dapp_reg <= desc_reg[W_DAPP][31:16];
        end else if (state_reg == S_CHK && !blk_err) begin
            if (!sflg[SF_REF_FIX]) begin
                sref_reg <= sref_reg + 32'h1;
            end
            if (sflg[SF_APP_INC]) begin
                sapp_reg <= sapp_reg + 16'h1;
            end
            if (dflg[DF_REF_PASS]) begin
                dref_reg <= rx_ref;
            end else if (!dflg[SF_REF_FIX]) begin
                dref_reg <= dref_reg + 32'h1;
            end
            if (dflg[SF_APP_INC]) begin
                dapp_reg <= dapp_reg + 16'h1;
            end
        end
    end

    // Completion record; source tags, and for update the destination tags, stay readable after the run ends
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= ST_NONE;
            dst_st_reg <= 8'h0;
            cr_bytes_reg <= 32'h0;
            cr_fault_reg <= 64'h0;
        end else if (start) begin
            dst_st_reg <= 8'h0;
            cr_bytes_reg <= 32'h0;
            cr_fault_reg <= 64'h0;
            if (!(is_upd || is_strip)) begin
                st_reg <= ST_BADOP;
            end else if (ovl) begin
                st_reg <= ST_OVERLAP;
            end else if (xfer == 32'h0) begin
                st_reg <= ST_OK;
            end else begin
                st_reg <= ST_NONE;
            end
        end else if ((rd_ack || wr_ack) && mem_fault) begin
            st_reg <= ST_FAULT;
            cr_fault_reg <= mem_address;
            cr_bytes_reg <= done_reg;
        end else if (state_reg == S_CHK && blk_err) begin
            st_reg <= ST_DIFERR;
            dst_st_reg <= dif_code;
            cr_bytes_reg <= done_reg;
        end else if ((state_reg == S_CHK && left_reg == 32'h0)
                || (step && last && !blk_end)) begin
            st_reg <= ST_OK;
            cr_bytes_reg <= xfer;
        end
    end

    // Memory port
    assign mem_read = state_reg == S_RD;
    assign mem_write = state_reg == S_WR;
    assign mem_address = mem_write ? dst_reg : src_reg;
    assign mem_writedata = (is_upd && in_dif) ? gen_byte : byte_reg;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_strip_no_field: assert property (mem_write && is_strip |-> !in_dif)
        else $error("strip wrote an integrity byte");
    a_update_writes: assert property (rd_ack && !mem_fault && is_upd |=> mem_write)
        else $error("update skipped a destination byte");
    a_read_bounded: assert property (mem_read |-> left_reg != 32'h0)
        else $error("read beyond transfer size");
    a_err_halts: assert property (state_reg == S_CHK && blk_err
        |=> state_reg == S_IDLE && st_reg == ST_DIFERR)
        else $error("integrity error did not halt");
    a_err_count: assert property (state_reg == S_CHK && blk_err
        |=> cr_bytes_reg == $past(done_reg))
        else $error("completed count includes failing block");
    a_ref_steps: assert property (state_reg == S_CHK && !blk_err && !sflg[SF_REF_FIX]
        |=> sref_reg == $past(sref_reg) + 32'h1)
        else $error("reference tag did not advance");
    a_app_fixed: assert property (state_reg == S_CHK && !sflg[SF_APP_INC]
        |=> $stable(sapp_reg))
        else $error("fixed application tag changed");
    a_overlap_err: assert property (start && ovl && (is_upd || is_strip)
        |=> st_reg == ST_OVERLAP && state_reg == S_IDLE)
        else $error("overlap not refused");
    a_fault_record: assert property ((rd_ack || wr_ack) && mem_fault
        |=> st_reg == ST_FAULT && cr_fault_reg == $past(mem_address))
        else $error("fault not recorded");
    a_seed_load: assert property (start |=> crc_reg == (gflg[GF_INV_SEED] ? CRC_ONES : 16'h0))
        else $error("guard seed wrong");
endmodule

// ### bench/dsu_mem_model.sv
// Byte-wide system memory model for the engine's memory port.
// Assumes requests are held until waitrequest is sampled low.
`timescale 1ns/100ps
module dsu_mem_model (
    input wire logic core_clk,
    input wire logic [63:0] mem_address,
    input wire logic mem_read,
    input wire logic mem_write,
    input wire logic [7:0] mem_writedata,
    output logic [7:0] mem_readdata,
    output logic mem_fault,
    output logic mem_waitrequest,
    input wire logic slow,
    input wire logic fault_en,
    input wire logic [63:0] fault_addr
);
    logic [7:0] mem [0:4095];
    logic stall_reg = 1'b0;
    logic [7:0] cyc_reg = 8'h00;
    int n_wr = 0;
    // Slow mode stalls every other cycle so held requests get exercised
    always @(posedge core_clk) begin
        stall_reg <= slow & ~stall_reg;
        cyc_reg <= cyc_reg + 8'h01;
        if (mem_write && !mem_waitrequest && !mem_fault) begin
            mem[mem_address[11:0]] <= mem_writedata;
            n_wr <= n_wr + 1;
        end
    end
    assign mem_waitrequest = stall_reg & (mem_read | mem_write);
    // Outside an accepted read the data changes every cycle, so stale bytes never match
    assign mem_readdata = (mem_read && !stall_reg) ? mem[mem_address[11:0]] : cyc_reg ^ 8'h3C;
    assign mem_fault = fault_en && (mem_read || mem_write) && (mem_address == fault_addr);
endmodule

// ### bench/test_dif_strip_update_engine.sv
// Self-checking bench for the integrity strip and update copy engine.
// Assumes one 250 MHz clock and a memory model behind the byte port.
`timescale 1ns/100ps
module test_dif_strip_update_engine;
    import dsu_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [6:0] av_address = 7'h00;
    logic av_read = 1'b0;
    logic av_write = 1'b0;
    logic [31:0] av_writedata = 32'h0;
    logic [31:0] av_readdata;
    logic av_waitrequest;
    logic [63:0] mem_address;
    logic mem_read, mem_write, mem_fault, mem_waitrequest, busy;
    logic [7:0] mem_writedata, mem_readdata;
    logic slow = 1'b0;
    logic fault_en = 1'b0;
    logic [63:0] fault_addr = 64'h0;
    int n_fail = 0;
    int num_checks = 0;

    always #2 core_clk = ~core_clk;

    dsu_engine i_dut (.core_clk(core_clk), .resetn(resetn), .av_address(av_address),
        .av_read(av_read), .av_write(av_write), .av_writedata(av_writedata),
        .av_byteenable(4'hF), .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
        .mem_address(mem_address), .mem_read(mem_read), .mem_write(mem_write),
        .mem_writedata(mem_writedata), .mem_readdata(mem_readdata), .mem_fault(mem_fault),
        .mem_waitrequest(mem_waitrequest), .busy(busy));
    dsu_mem_model i_mem (.core_clk(core_clk), .mem_address(mem_address), .mem_read(mem_read),
        .mem_write(mem_write), .mem_writedata(mem_writedata), .mem_readdata(mem_readdata),
        .mem_fault(mem_fault), .mem_waitrequest(mem_waitrequest), .slow(slow),
        .fault_en(fault_en), .fault_addr(fault_addr));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Request is held until the edge that samples waitrequest low
    task automatic av_wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge core_clk);
        av_address <= a;
        av_writedata <= d;
        av_write <= 1'b1;
        @(posedge core_clk iff av_waitrequest === 1'b0);
        av_write <= 1'b0;
    endtask
    task automatic av_rd(input logic [6:0] a, output logic [31:0] d);
        @(posedge core_clk);
        av_address <= a;
        av_read <= 1'b1;
        @(posedge core_clk iff av_waitrequest === 1'b0);
        d = av_readdata;
        av_read <= 1'b0;
    endtask
    function automatic logic [7:0] pat(input int i);
        return 8'(i) ^ 8'h5A;
    endfunction
    function automatic logic [15:0] guard(input logic [7:0] gf);
        logic [15:0] c;
        c = gf[2] ? CRC_ONES : 16'h0000;
        for (int i = 0; i < 512; i++) begin
            c ^= {pat(i), 8'h00};
            for (int b = 0; b < 8; b++)
                c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return gf[3] ? ~c : c;
    endfunction
    // Source block: 512 payload bytes then the field, big-endian
    task automatic fill(input int a, input logic [7:0] gf, input logic [63:0] f);
        for (int i = 0; i < 512; i++)
            i_mem.mem[12'(a + i)] = pat(i);
        for (int k = 0; k < 8; k++)
            i_mem.mem[12'(a + 512 + k)] = f[63 - 8 * k -: 8];
    endtask
    function automatic int payload_err(input int a);
        int e;
        e = 0;
        for (int i = 0; i < 512; i++)
            e += (i_mem.mem[12'(a + i)] !== pat(i));
        return e;
    endfunction
    task automatic run(input logic [7:0] op, input logic [31:0] src, input logic [31:0] dst,
        input logic [23:0] flg, input logic [31:0] sref, input logic [31:0] dref);
        int n;
        av_wr(7'h04, {op, 24'h0});
        av_wr(7'h10, src);
        av_wr(7'h14, 32'h0);
        av_wr(7'h18, dst);
        av_wr(7'h1C, 32'h0);
        av_wr(7'h20, 32'd520);
        av_wr(7'h28, {8'h00, flg});
        av_wr(7'h30, sref);
        av_wr(7'h34, 32'h2222_0000);
        av_wr(7'h38, dref);
        av_wr(7'h3C, 32'h3333_0000);
        av_wr(A_CTRL, 32'h1);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (busy !== 1'b0 && n < 8000);
        check("busy", {31'h0, busy}, 32'h0);
    endtask

    task automatic t_regs;
        logic [31:0] d;
        av_rd(A_COMP, d);
        check("status at reset", d, 32'h0);
        av_wr(7'h64, 32'hFFFF_FFFF);
        av_rd(7'h64, d);
        check("unmapped", d, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_strip_ok;
        logic [31:0] d;
        int w0;
        for (int i = 0; i < 520; i++)
            i_mem.mem[12'(32'h801 + i)] = 8'hEE;
        fill(32'h101, 8'h00, {guard(8'h00), 16'h2222, 32'h40});
        w0 = i_mem.n_wr;
        run(OP_STRIP, 32'h101, 32'h801, 24'h0, 32'h40, 32'h0);
        av_rd(A_COMP, d);
        check("strip status", d[15:0], {8'h00, ST_OK});
        av_rd(7'h44, d);
        check("strip count", d, 32'd520);
        check("strip writes", i_mem.n_wr - w0, 32'd512);
        check("strip payload", payload_err(32'h801), 32'h0);
        check("field dropped", {24'h0, i_mem.mem[12'hA01]}, 32'hEE);
        $display("test strip_ok done");
    endtask
    task automatic t_strip_bad;
        logic [31:0] d;
        for (int k = 0; k < 2; k++) begin
            fill(32'h101, 8'h00, {guard(8'h00) ^ 16'h0001, 16'h2222, 32'h40});
            run(OP_STRIP, 32'h101, 32'h801, k ? 24'h20 : 24'h0, 32'h40, 32'h0);
            av_rd(A_COMP, d);
            check("bad status", d[15:0], k ? {8'h00, ST_OK} : {8'h01, ST_DIFERR});
            av_rd(7'h44, d);
            check("bad count", d, k ? 32'd520 : 32'd0);
        end
        $display("test strip_bad done");
    endtask
    task automatic t_update;
        logic [31:0] d;
        logic [63:0] f;
        int w0;
        slow <= 1'b1;
        fill(32'h133, 8'h0C, {guard(8'h0C), 16'h2222, 32'h77});
        w0 = i_mem.n_wr;
        run(OP_UPDATE, 32'h133, 32'h903, 24'h0C0000, 32'h77, 32'h500);
        av_rd(A_COMP, d);
        check("update status", d[15:0], {8'h00, ST_OK});
        av_rd(7'h44, d);
        check("update count", d, 32'd520);
        av_rd(7'h50, d);
        check("final src ref", d, 32'h78);
        av_rd(7'h54, d);
        check("final src app", d, 32'h2222_0000);
        av_rd(7'h58, d);
        check("final dest ref", d, 32'h501);
        check("update writes", i_mem.n_wr - w0, 32'd520);
        check("update payload", payload_err(32'h903), 32'h0);
        f = {guard(8'h0C), 16'h3333, 32'h500};
        for (int k = 0; k < 8; k++)
            check("new field", {24'h0, i_mem.mem[12'(32'hB03 + k)]}, {24'h0, f[63 - 8 * k -: 8]});
        slow <= 1'b0;
        $display("test update done");
    endtask
    task automatic t_overlap;
        logic [31:0] d;
        int w0;
        w0 = i_mem.n_wr;
        run(OP_STRIP, 32'h100, 32'h200, 24'h0, 32'h0, 32'h0);
        av_rd(A_COMP, d);
        check("overlap status", d[7:0], {24'h0, ST_OVERLAP});
        check("overlap writes", i_mem.n_wr - w0, 32'd0);
        run(8'h7F, 32'h101, 32'h801, 24'h0, 32'h0, 32'h0);
        av_rd(A_COMP, d);
        check("bad opcode", d[7:0], {24'h0, ST_BADOP});
        check("bad opcode writes", i_mem.n_wr - w0, 32'd0);
        $display("test overlap done");
    endtask
    task automatic t_fault;
        logic [31:0] d;
        logic [7:0] op;
        fault_addr <= 64'h104;
        fault_en <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            op = k ? OP_UPDATE : OP_STRIP;
            fill(32'h101, 8'h00, {guard(8'h00), 16'h2222, 32'h40});
            run(op, 32'h101, 32'h801, 24'h0, 32'h40, 32'h600);
            av_rd(A_COMP, d);
            check("fault status", d[7:0], {24'h0, ST_FAULT});
            av_rd(7'h48, d);
            check("fault address", d, 32'h104);
            av_rd(7'h50, d);
            check("fault ref", d, 32'h40);
            av_rd(7'h58, d);
            check("fault dest ref", d, k ? 32'h600 : 32'h0);
        end
        fault_en <= 1'b0;
        // Resume with the reference tag taken from the record
        av_rd(7'h50, d);
        run(OP_UPDATE, 32'h101, 32'h801, 24'h0, d, 32'h600);
        av_rd(A_COMP, d);
        check("resume status", d[15:0], {8'h00, ST_OK});
        $display("test fault done");
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        t_regs();
        t_strip_ok();
        t_strip_bad();
        t_update();
        t_overlap();
        t_fault();
        final_report();
    end
    // Whole run needs about 7000 cycles; over eight times that means a hang
    initial begin
        repeat (60000) @(posedge core_clk);
        n_fail++;
        final_report();
    end
endmodule
